/* File: logic/strap_pkg.sv */
// How it works
// (RL1) Strap pins act as inputs during reset
// (RL2) Latch strap levels when hard reset deasserts
// (RL3) After capture, receiver off, pins drive outputs
// (RL4) Most straps have switchable internal pull-up; here only bits 15:8, half of the 16
// (RL5) Pull-up on in reset plus few cycles
// (RL6) Receiver off means pull-up off too
// (RL7) Sampled high selects default setting
// (RL8) Board pulls low only for non-default straps
// (RL9) PLL ratio straps carry no internal pull-up
// (RL10) Latched values hold until next reset
package strap_pkg;
    // Strap count and pull-up hold after release
    localparam int STRAP_COUNT = 16;
    localparam int PULL_HOLD_CYCLES = 4;
    localparam int HOLD_WIDTH = 3;
    // Straps without internal pull-up (PLL ratio group)
    localparam logic [15:0] NO_PULL_MASK = 16'h00FF;
    // Reset value of latched config: default all ones
    localparam logic [15:0] CFG_RESET_VALUE = 16'hFFFF;
    localparam logic [2:0] HOLD_RESET_VALUE = 3'h0;
endpackage

/* File: logic/reset_strap_sampler.sv */
`timescale 1ns/10ps
module reset_strap_sampler #(
    parameter int WIDTH = strap_pkg::STRAP_COUNT,
    parameter int HOLD = strap_pkg::PULL_HOLD_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Hard reset pin, active low, asynchronous to clock
    input wire logic hard_reset_n_in,
    // Strap pins: pad input, functional data, pad drive
    input wire logic [WIDTH-1:0] pad_in,
    input wire logic [WIDTH-1:0] func_data_in,
    output logic [WIDTH-1:0] pad_out,
    output logic [WIDTH-1:0] pad_oe_out,
    output logic [WIDTH-1:0] pad_pullup_en_out,
    output logic [WIDTH-1:0] pad_rx_en_out,
    // Latched configuration
    output logic [WIDTH-1:0] cfg_out,
    output logic cfg_valid_out
);
    // Width of the pull-up hold counter
    localparam int HW = strap_pkg::HOLD_WIDTH;

    // Refuse sizes that the mask and hold counter cannot serve
    if (WIDTH != strap_pkg::STRAP_COUNT) begin : g_bad_width
        $error("reset_strap_sampler: WIDTH must equal strap count");
    end
    if (HOLD < 1 || HOLD > 7) begin : g_bad_hold
        $error("reset_strap_sampler: HOLD out of range 1 to 7");
    end

    // Counter load on release: pull-up kept HOLD more cycles
    localparam logic [HW-1:0] HOLD_LOAD = HW'(HOLD - 1);
    localparam logic [HW-1:0] HOLD_ONE = HW'(1);

    // Phases of one hard reset cycle
    typedef enum logic [1:0] {
        PH_SAMPLE = 2'b00, // Hard reset low, pins are inputs
        PH_HOLD = 2'b01, // Released, pull-up kept a few cycles
        PH_RUN = 2'b10 // Captured, pins are outputs again
    } phase_type;

    // Whole state of the block
    typedef struct packed {
        logic [1:0] hr_sync;
        logic [WIDTH-1:0] pin_s1;
        logic [WIDTH-1:0] pin_s2;
        logic [WIDTH-1:0] cfg;
        logic in_reset;
        logic [HW-1:0] hold;
        phase_type phase;
        logic [WIDTH-1:0] pad_o;
    } state_type;

    state_type st_r;
    state_type st_nxt;

    // Receiver stays on until the value is captured
    function automatic logic rx_phase(input phase_type ph);
        rx_phase = (ph != PH_RUN);
    endfunction

    // PLL ratio straps never get the internal pull-up
    function automatic logic pull_allowed(input int idx);
        pull_allowed = ~strap_pkg::NO_PULL_MASK[idx];
    endfunction

    // Next state: synchronise pins, walk the phases, latch
    always_comb begin
        st_nxt = st_r;
        // Two flops on the async hard reset pin
        st_nxt.hr_sync = {st_r.hr_sync[0], hard_reset_n_in};
        // Two flops on every strap pad
        st_nxt.pin_s1 = pad_in;
        st_nxt.pin_s2 = st_r.pin_s1;
        st_nxt.in_reset = ~st_r.hr_sync[1];
        // Functional data goes out one cycle later
        st_nxt.pad_o = func_data_in;
        case (st_r.phase)
            PH_SAMPLE: begin
                // Pins are inputs; counter armed for release
                st_nxt.hold = HOLD_LOAD;
                if (st_r.hr_sync[1]) begin
                    st_nxt.phase = PH_HOLD; // RL5
                end
            end
            PH_HOLD: begin
                if (!st_r.hr_sync[1]) begin
                    // Reasserted before capture: start over
                    st_nxt.phase = PH_SAMPLE; // RL1
                    st_nxt.hold = HOLD_LOAD;
                end else if (st_r.hold != '0) begin
                    st_nxt.hold = st_r.hold - HOLD_ONE; // RL5
                end else begin
                    // Value settled under the pull-up: latch it
                    st_nxt.cfg = st_r.pin_s2; // RL2
                    st_nxt.phase = PH_RUN; // RL3
                end
            end
            PH_RUN: begin
                // Config frozen until hard reset comes back
                if (!st_r.hr_sync[1]) begin
                    st_nxt.phase = PH_SAMPLE; // RL1 RL10
                end
            end
            default: begin
                st_nxt.phase = PH_SAMPLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            st_r <= '{hr_sync: 2'h0, pin_s1: '0, pin_s2: '0,
                cfg: strap_pkg::CFG_RESET_VALUE, in_reset: 1'b1,
                hold: strap_pkg::HOLD_RESET_VALUE, phase: PH_SAMPLE,
                pad_o: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Per-pin pad control: pull-up only with receiver
    for (genvar i = 0; i < WIDTH; i++) begin : g_pad
        assign pad_rx_en_out[i] = rx_phase(st_r.phase); // RL1 RL3
        assign pad_pullup_en_out[i] = rx_phase(st_r.phase)
            & pull_allowed(i); // RL4 RL6 RL9
        assign pad_oe_out[i] = ~rx_phase(st_r.phase); // RL3

        // A pulled-up pin is never driven by the chip
        a_bit_pull: assert property (@(posedge sys_clk_in)
            disable iff (!rst_n_in)
            pad_pullup_en_out[i] |-> pad_rx_en_out[i] && !pad_oe_out[i])
            else $error("pull-up on a driven pin"); // RL6
    end

    // Registered data outputs
    assign pad_out = st_r.pad_o;
    // Default ones until latch; high means default
    assign cfg_out = st_r.cfg; // RL7 RL10
    assign cfg_valid_out = ~rx_phase(st_r.phase);

    // Latched value stays put while not sampling
    a_cfg_stable: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        cfg_valid_out && $past(cfg_valid_out) |-> $stable(cfg_out))
        else $error("cfg changed outside capture"); // RL10
    a_pull_with_rx: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        (pad_pullup_en_out & ~pad_rx_en_out) == '0)
        else $error("pull-up on while receiver off"); // RL6
    a_no_pll_pull: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        (pad_pullup_en_out & strap_pkg::NO_PULL_MASK) == '0)
        else $error("pull-up on PLL strap"); // RL9
    a_input_in_reset: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        st_r.in_reset |-> pad_oe_out == '0)
        else $error("strap driven during reset"); // RL1
    sequence release_seq;
        st_r.in_reset ##1 !st_r.in_reset;
    endsequence
    sequence capture_seq;
        st_r.phase == PH_HOLD && st_nxt.phase == PH_RUN;
    endsequence
    // Pull-up held for the hold cycles after release
    a_pull_hold: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        release_seq |-> pad_pullup_en_out != '0 [*4])
        else $error("pull-up dropped too early"); // RL5
    // Latched value is the pad level seen two flops earlier
    a_capture_value: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        capture_seq |=> cfg_out == $past(pad_in, 3))
        else $error("captured value wrong"); // RL2
    // Hard reset seen again: pins go back to inputs
    a_reenter: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        $fell(st_r.hr_sync[1]) |=> !cfg_valid_out)
        else $error("no resample on hard reset"); // RL1
    // After capture the pins carry functional data
    a_pad_follow: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        cfg_valid_out |=> pad_out == $past(func_data_in))
        else $error("pad data not functional"); // RL3
    a_release_done: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        release_seq |-> ##[1:8] cfg_valid_out)
        else $error("capture not completed"); // RL3
    a_oe_after: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        cfg_valid_out |-> pad_oe_out == '1 && pad_rx_en_out == '0)
        else $error("pin not back to output"); // RL3
endmodule

/* File: verif/strap_board.sv */
`timescale 1ns/10ps
// Board resistors set each pin while the chip is not driving it
module strap_board (
    input wire logic [15:0] strap_in,
    input wire logic [15:0] oe_in,
    input wire logic [15:0] drive_in,
    input wire logic [15:0] pullup_in,
    output logic [15:0] level_out
);
    // PLL ratio straps are set both ways by the board
    localparam logic [15:0] BOARD_DRIVEN = 16'h00FF;
    logic [15:0] undriven;
    // Pull-low-only straps read high only through the chip pull-up
    assign undriven = (strap_in & BOARD_DRIVEN)
        | (strap_in & ~BOARD_DRIVEN & pullup_in);
    // Driven bits follow the chip, the rest the board
    assign level_out = (oe_in & drive_in) | (~oe_in & undriven);
endmodule

/* File: verif/tb_reset_strap_sampler.sv */
`timescale 1ns/10ps
module tb_reset_strap_sampler;
    logic clk = 0, rst_n = 0, hr_n = 0, vld;
    logic [15:0] strap = 16'h0000, fd = 16'h0000;
    logic [15:0] pad, po, oe, pu, rx, cfg;
    int mismatches = 0, n_compared = 0, cyc = 0;
    // Clock, 4 ns period
    always #2 clk = ~clk;
    reset_strap_sampler DUT (.sys_clk_in(clk), .rst_n_in(rst_n),
        .hard_reset_n_in(hr_n), .pad_in(pad), .func_data_in(fd),
        .pad_out(po), .pad_oe_out(oe), .pad_pullup_en_out(pu),
        .pad_rx_en_out(rx), .cfg_out(cfg), .cfg_valid_out(vld));
    strap_board board (.strap_in(strap), .oe_in(oe), .drive_in(po),
        .pullup_in(pu), .level_out(pad));
    // Compare and report
    task chk(string n, logic [15:0] e, logic [15:0] s);
        n_compared++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    // Counts and verdict
    task end_of_test;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            mismatches++;
            end_of_test;
        end
    end
    // Hard reset with strap pattern p, release, then disturb the pins
    task capture(logic [15:0] p);
        hr_n = 0;
        strap = p;
        repeat (4) @(negedge clk);
        chk("oe", 16'h0000, oe);
        chk("rx", 16'hFFFF, rx);
        chk("pull", 16'hFF00, pu);
        hr_n = 1;
        repeat (2) @(negedge clk);
        chk("pull_hold", 16'hFF00, pu);
        repeat (20) if (vld !== 1'b1) @(negedge clk);
        chk("valid", 16'h0001, {15'h0000, vld});
        chk("cfg", p, cfg);
        chk("oe_on", 16'hFFFF, oe);
        chk("rx_off", 16'h0000, rx);
        chk("pull_off", 16'h0000, pu);
        strap = ~p;
        fd = ~p ^ 16'hA55A;
        repeat (3) @(negedge clk);
        chk("cfg_hold", p, cfg);
        chk("func", ~p ^ 16'hA55A, po);
        $display("capture %h done", p);
    endtask
    // Values right after the opening reset
    task reset_check;
        chk("cfg_rst", 16'hFFFF, cfg);
        chk("valid_rst", 16'h0000, {15'h0000, vld});
        $display("reset_check done");
    endtask
    // Sync reset in mid-run: defaults back, then recapture
    task mid_reset(logic [15:0] p);
        strap = p;
        rst_n = 0;
        @(negedge clk);
        rst_n = 1;
        chk("cfg_mid", 16'hFFFF, cfg);
        chk("oe_mid", 16'h0000, oe);
        repeat (20) if (vld !== 1'b1) @(negedge clk);
        chk("cfg_re", p, cfg);
        $display("mid_reset %h done", p);
    endtask
    // Main sequence
    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1;
        reset_check;
        capture(16'h5AC3);
        mid_reset(16'h3C96);
        capture(16'hFFFF);
        capture(16'h0F00);
        end_of_test;
    end
endmodule
